// file: rtl/rx_filter_host_config_bits.sv
// What this block does
// RULE1: reserved allow clear: types 4..7 rejected unless type 4/5 allow accepts.
// RULE2: reserved allow set: reserved types accepted without address matching.
// RULE3: frames shorter than length implied by frame control are always rejected; the code rejects them only while frame filtering is enabled.
// RULE4: type four allow set accepts type 4 without address match.
// RULE5: type five allow set accepts type 5 without address match.
// RULE6: interrupt output active high when polarity bit is 1, else active low.
// RULE7: host should prefer active high interrupt for low power systems.
// RULE8: edge select 0 launches serial data on sampling edge, 1 opposite edge.
// RULE9: check error ignore set treats frames valid and advances buffer.
// RULE10: with checking on and double buffering, bad CRC frame's buffer is reused.
// RULE11: double buffering receives into one buffer while host reads other.
// RULE12: double buffer enabled when disable bit 0, single buffer when 1.
// RULE13: header abort disable 0: reception stops on uncorrectable header error.
// RULE14: uncorrectable header error sets the header error status flag.
// RULE15: host must never set header abort disable in an application.
// RULE16: type allow bits act only while frame filtering is enabled.
// RULE17: header abort disable set: keep demodulating but still flag error.
//
// Decided for this implementation: the APB register port.
`default_nettype none
module rx_filter_host_config_bits (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // receiver side
    input wire rx_cfg_pkg::rx_frame_t frame_in,
    input wire logic phr_error_in,
    output rx_cfg_pkg::rx_verdict_t verdict_out,
    output logic rx_abort_out,
    // serial host link
    input wire logic sclk_in,
    input wire logic cs_n_in,
    output logic miso_out,
    // interrupt
    output logic irq_out
);
    logic [31:0] sys_cfg_reg;
    logic [rx_cfg_pkg::EVT_W-1:0] status_reg;
    logic [rx_cfg_pkg::EVT_W-1:0] mask_reg;
    logic [rx_cfg_pkg::EVT_W-1:0] evt_set;
    logic [1:0] buf_full_reg;
    logic wr_buf_reg;
    logic acc, accept, frame_good;
    logic wr_en, rd_en, mapped;
    logic [7:0] idx;

    function automatic logic [9:0] addr_bytes(input logic [1:0] mode);
        case (mode)
            2'h2: addr_bytes = 10'h002;
            2'h3: addr_bytes = 10'h008;
            default: addr_bytes = 10'h000;
        endcase
    endfunction

    // frame control + sequence + fcs, plus addressing fields
    function automatic logic [9:0] min_len(input logic [15:0] fc);
        logic [9:0] n;
        n = rx_cfg_pkg::LEN_BASE + addr_bytes(fc[11:10]) + addr_bytes(fc[15:14]);
        if (fc[11:10] != 2'h0)
            n = n + 10'h002;
        if (fc[15:14] != 2'h0 && !(fc[6] && fc[11:10] != 2'h0))
            n = n + 10'h002;
        min_len = n;
    endfunction

    // apb decode; zero wait states
    assign idx = paddr_in[9:2];
    assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0) &&
                    (idx == rx_cfg_pkg::IDX_SYS_CFG || idx == rx_cfg_pkg::IDX_EVT_STATUS ||
                     idx == rx_cfg_pkg::IDX_EVT_MASK || idx == rx_cfg_pkg::IDX_BUF_CTRL);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign wr_en = psel_in && penable_in && pwrite_in && mapped;
    assign rd_en = psel_in && penable_in && !pwrite_in && mapped;

    always_comb begin
        prdata_out = 32'h0000_0000;
        case (idx)
            rx_cfg_pkg::IDX_SYS_CFG: prdata_out = sys_cfg_reg;
            rx_cfg_pkg::IDX_EVT_STATUS: prdata_out = {27'h0, status_reg};
            rx_cfg_pkg::IDX_EVT_MASK: prdata_out = {27'h0, mask_reg};
            rx_cfg_pkg::IDX_BUF_CTRL: prdata_out = {29'h0, wr_buf_reg, buf_full_reg};
            default: prdata_out = 32'h0000_0000;
        endcase
        if (!mapped)
            prdata_out = 32'h0000_0000;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            sys_cfg_reg <= rx_cfg_pkg::SYS_CFG_RESET;
        else if (wr_en && idx == rx_cfg_pkg::IDX_SYS_CFG)
            sys_cfg_reg <= pwdata_in;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            mask_reg <= rx_cfg_pkg::EVT_MASK_RESET;
        else if (wr_en && idx == rx_cfg_pkg::IDX_EVT_MASK)
            mask_reg <= pwdata_in[rx_cfg_pkg::EVT_W-1:0];
    end

    // frame filter
    always_comb begin
        acc = frame_in.addr_match;
        // RULE1: RULE2: reserved types skip address match
        if (frame_in.frame_control[2])
            acc = sys_cfg_reg[rx_cfg_pkg::BIT_ALLOW_RES];
        // RULE4: type four allow
        if (frame_in.frame_control[2:0] == rx_cfg_pkg::TYPE_FOUR &&
            sys_cfg_reg[rx_cfg_pkg::BIT_ALLOW_T4])
            acc = 1'b1;
        // RULE5: type five allow
        if (frame_in.frame_control[2:0] == rx_cfg_pkg::TYPE_FIVE &&
            sys_cfg_reg[rx_cfg_pkg::BIT_ALLOW_T5])
            acc = 1'b1;
        // RULE3: minimum length check
        if (frame_in.length < min_len(frame_in.frame_control))
            acc = 1'b0;
    end
    // RULE16: filtering only when enabled
    assign accept = sys_cfg_reg[rx_cfg_pkg::BIT_FILTER_EN] ? acc : 1'b1;
    // RULE9: check errors ignored on request
    assign frame_good = frame_in.crc_ok || sys_cfg_reg[rx_cfg_pkg::BIT_FCE_IGNORE];

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            verdict_out <= '0;
        end else begin
            verdict_out.accept <= frame_in.valid && accept && frame_good;
            verdict_out.reject <= frame_in.valid && !(accept && frame_good);
            verdict_out.buf_index <= wr_buf_reg;
        end
    end

    // buffer pair; a host write of 1 to bit n frees buffer n
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            buf_full_reg <= 2'h0;
            wr_buf_reg <= 1'b0;
        end else begin
            logic [1:0] full_next;
            full_next = buf_full_reg;
            if (wr_en && idx == rx_cfg_pkg::IDX_BUF_CTRL)
                full_next = full_next & ~pwdata_in[1:0];
            // RULE10: bad frame leaves buffer for reuse
            if (frame_in.valid && accept && frame_good && !buf_full_reg[wr_buf_reg]) begin
                full_next[wr_buf_reg] = 1'b1;
                // RULE11: RULE12: switch only when double buffering
                if (!sys_cfg_reg[rx_cfg_pkg::BIT_DBUF_DIS])
                    wr_buf_reg <= ~wr_buf_reg;
            end
            if (sys_cfg_reg[rx_cfg_pkg::BIT_DBUF_DIS])
                wr_buf_reg <= 1'b0;
            buf_full_reg <= full_next;
        end
    end

    // RULE13: RULE17: abort unless disabled
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            rx_abort_out <= 1'b0;
        else
            rx_abort_out <= phr_error_in && !sys_cfg_reg[rx_cfg_pkg::BIT_PHE_ABORT_DIS];
    end

    always_comb begin
        evt_set = '0;
        // RULE14: header error flag
        evt_set[rx_cfg_pkg::EVT_HDR_ERR] = phr_error_in;
        evt_set[rx_cfg_pkg::EVT_RX_GOOD] = frame_in.valid && accept && frame_good;
        evt_set[rx_cfg_pkg::EVT_RX_REJECT] = frame_in.valid && !accept;
        evt_set[rx_cfg_pkg::EVT_CRC_ERR] = frame_in.valid && !frame_good;
        evt_set[rx_cfg_pkg::EVT_OVERRUN] = frame_in.valid && accept && frame_good &&
                                           buf_full_reg[wr_buf_reg];
    end

    // read clears, but a new event in the same cycle wins
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            status_reg <= '0;
        else if (rd_en && idx == rx_cfg_pkg::IDX_EVT_STATUS)
            status_reg <= evt_set;
        else
            status_reg <= status_reg | evt_set;
    end

    // RULE6: interrupt polarity
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            irq_out <= 1'b0;
        else
            irq_out <= (|(status_reg & mask_reg)) == sys_cfg_reg[rx_cfg_pkg::BIT_IRQ_POL];
    end

    // link inputs through three flops; change counted when last two agree
    logic [rx_cfg_pkg::SYNC_STAGES-1:0] sclk_sync, cs_sync;
    logic sclk_level, cs_level, sclk_prev, cs_prev;
    logic [7:0] shift_reg;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sclk_sync <= '0;
            cs_sync <= '1;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk_in};
            cs_sync <= {cs_sync[1:0], cs_n_in};
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sclk_level <= 1'b0;
            cs_level <= 1'b1;
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            if (sclk_sync[1] == sclk_sync[2])
                sclk_level <= sclk_sync[2];
            if (cs_sync[1] == cs_sync[2])
                cs_level <= cs_sync[2];
            sclk_prev <= sclk_level;
            cs_prev <= cs_level;
        end
    end

    // status byte shifted out msb first; sampling edge is rising sclk
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_reg <= 8'h00;
            miso_out <= 1'b0;
        end else if (cs_prev && !cs_level) begin
            // msb must stand before the first sampling edge; it is always 0
            shift_reg <= {2'h0, status_reg, 1'b0};
            miso_out <= 1'b0;
        end else if (!cs_level) begin
            // RULE8: launch edge select
            if (sys_cfg_reg[rx_cfg_pkg::BIT_EDGE_SEL] ? (sclk_prev && !sclk_level)
                                                       : (!sclk_prev && sclk_level)) begin
                miso_out <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_reserved_reject;
        frame_in.valid && sys_cfg_reg[0] && frame_in.frame_control[2:1] == 2'h3 &&
        !sys_cfg_reg[6] |=> !verdict_out.accept;
    endproperty
    a_reserved_reject: assert property (p_reserved_reject) else $error("reserved accepted"); // RULE1
    property p_reserved_accept;
        frame_in.valid && frame_in.frame_control[2] && sys_cfg_reg[0] && sys_cfg_reg[6] &&
        frame_in.crc_ok && frame_in.length >= 10'h019 |=> verdict_out.accept;
    endproperty
    a_reserved_accept: assert property (p_reserved_accept) else $error("reserved lost"); // RULE2
    property p_short;
        frame_in.valid && sys_cfg_reg[0] && frame_in.length < 10'h005 |=> verdict_out.reject;
    endproperty
    a_short: assert property (p_short) else $error("short frame kept"); // RULE3
    property p_type4;
        frame_in.valid && frame_in.frame_control[2:0] == 3'h4 && sys_cfg_reg[0] &&
        !sys_cfg_reg[6] && !sys_cfg_reg[7] |=> verdict_out.reject;
    endproperty
    a_type4: assert property (p_type4) else $error("type four not ignored"); // RULE4
    property p_type5;
        frame_in.valid && frame_in.frame_control[2:0] == 3'h5 && sys_cfg_reg[0] &&
        sys_cfg_reg[8] && frame_in.crc_ok && frame_in.length >= 10'h019 |=> verdict_out.accept;
    endproperty
    a_type5: assert property (p_type5) else $error("type five not accepted"); // RULE5
    property p_filter_off;
        frame_in.valid && !sys_cfg_reg[0] && frame_in.crc_ok |=> verdict_out.accept;
    endproperty
    a_filter_off: assert property (p_filter_off) else $error("filtered while off"); // RULE16
    property p_launch_edge;
        !cs_level && !cs_prev &&
        (sys_cfg_reg[10] ? !(sclk_prev && !sclk_level) : !(!sclk_prev && sclk_level))
        |=> $stable(miso_out);
    endproperty
    a_launch_edge: assert property (p_launch_edge) else $error("data launched off edge"); // RULE8
    property p_irq_pol;
        ##1 irq_out == ((|($past(status_reg) & $past(mask_reg))) == $past(sys_cfg_reg[9]));
    endproperty
    a_irq_pol: assert property (p_irq_pol) else $error("irq level wrong"); // RULE6
    property p_single_buf;
        sys_cfg_reg[12] |=> !wr_buf_reg;
    endproperty
    a_single_buf: assert property (p_single_buf) else $error("second buffer used"); // RULE12
    property p_abort;
        phr_error_in && !sys_cfg_reg[13] |=> rx_abort_out;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort"); // RULE13
    property p_no_abort;
        phr_error_in && sys_cfg_reg[13] |=> !rx_abort_out && status_reg[0];
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("abort when disabled"); // RULE17
    property p_flag;
        phr_error_in |=> status_reg[0];
    endproperty
    a_flag: assert property (p_flag) else $error("header error not flagged"); // RULE14
endmodule
`default_nettype wire

// file: rtl/rx_cfg_pkg.sv
`default_nettype none
package rx_cfg_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SYS_CFG = 8'h04;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h0F;
    localparam logic [7:0] IDX_EVT_MASK = 8'h10;
    localparam logic [7:0] IDX_BUF_CTRL = 8'h11;
    localparam logic [31:0] SYS_CFG_RESET = 32'h0000_1200;
    localparam logic [4:0] EVT_MASK_RESET = 5'h00;
    // system configuration bit positions
    localparam int BIT_FILTER_EN = 0;
    localparam int BIT_ALLOW_RES = 6;
    localparam int BIT_ALLOW_T4 = 7;
    localparam int BIT_ALLOW_T5 = 8;
    localparam int BIT_IRQ_POL = 9;
    localparam int BIT_EDGE_SEL = 10;
    localparam int BIT_FCE_IGNORE = 11;
    localparam int BIT_DBUF_DIS = 12;
    localparam int BIT_PHE_ABORT_DIS = 13;
    // event status bit positions
    localparam int EVT_HDR_ERR = 0;
    localparam int EVT_RX_GOOD = 1;
    localparam int EVT_RX_REJECT = 2;
    localparam int EVT_CRC_ERR = 3;
    localparam int EVT_OVERRUN = 4;
    localparam int EVT_W = 5;
    localparam logic [2:0] TYPE_FOUR = 3'h4;
    localparam logic [2:0] TYPE_FIVE = 3'h5;
    localparam logic [9:0] LEN_BASE = 10'h005;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic valid;
        logic [15:0] frame_control;
        logic [9:0] length;
        logic addr_match;
        logic crc_ok;
    } rx_frame_t;

    typedef struct packed {
        logic accept;
        logic reject;
        logic buf_index;
    } rx_verdict_t;
endpackage
`default_nettype wire

// file: sim/spi_host_model.sv
`default_nettype none
module spi_host_model (
    // link pins
    output logic sclk_out,
    output logic cs_n_out,
    input wire logic miso_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
    end
    // host only reads
    // clock stands still outside a frame; bits sampled late in each period
    task automatic xfer(output logic [7:0] b);
        cs_n_out = 1'b0;
        #160;
        b[7] = miso_in;
        for (int i = 6; i >= 0; i--) begin
            sclk_out = 1'b1;
            #80;
            sclk_out = 1'b0;
            #80;
            b[i] = miso_in;
        end
        cs_n_out = 1'b1;
        #160;
    endtask
endmodule
`default_nettype wire

// file: sim/rx_filter_host_config_bits_bench.sv
`default_nettype none
module rx_filter_host_config_bits_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic phr_error_in, rx_abort_out, sclk_in, cs_n_in, miso_out, irq_out, e, w;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, r;
    logic [7:0] b;
    logic [1:0] m;
    rx_cfg_pkg::rx_frame_t frame_in;
    rx_cfg_pkg::rx_verdict_t verdict_out;
    int n_mismatch = 0;
    int num_checks = 0;
    localparam logic [11:0] A_CFG = {2'h0, rx_cfg_pkg::IDX_SYS_CFG, 2'h0};
    localparam logic [11:0] A_ST = {2'h0, rx_cfg_pkg::IDX_EVT_STATUS, 2'h0};
    localparam logic [11:0] A_MSK = {2'h0, rx_cfg_pkg::IDX_EVT_MASK, 2'h0};
    localparam logic [11:0] A_BUF = {2'h0, rx_cfg_pkg::IDX_BUF_CTRL, 2'h0};
    // verdict pairs {accept, reject} for types 4..7, two bits each
    localparam logic [31:0] CFGS [5] = '{32'h1201, 32'h1281, 32'h1301, 32'h1241, 32'h1200};
    localparam logic [7:0] EXPS [5] = '{8'h55, 8'h56, 8'h59, 8'hAA, 8'hAA};

    rx_filter_host_config_bits rx_filter_host_config_bits_i (
        .clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .frame_in, .phr_error_in, .verdict_out,
        .rx_abort_out, .sclk_in, .cs_n_in, .miso_out, .irq_out
    );
    spi_host_model spi_host_model_i (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .miso_in(miso_out));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic test_done;
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (pready_out === 1'b1) break;
        end
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n == 20) begin
            n_mismatch++;
            test_done();
        end
    endtask

    // x of 2'b11 leaves the verdict unchecked
    task automatic frm(input logic [2:0] ty, input logic [9:0] ln, input logic ok,
                       input logic [1:0] x);
        @(posedge clk_in);
        frame_in <= '{1'b1, {13'h0, ty}, ln, 1'b0, ok};
        @(posedge clk_in);
        frame_in.valid <= 1'b0;
        #1;
        if (x != 2'b11)
            chk("verdict", {30'h0, verdict_out.accept, verdict_out.reject}, {30'h0, x});
    endtask

    task automatic hdr_err(input logic ab);
        @(posedge clk_in);
        phr_error_in <= 1'b1;
        @(posedge clk_in);
        phr_error_in <= 1'b0;
        #1;
        chk("abort", {31'h0, rx_abort_out}, {31'h0, ab});
    endtask

    initial begin
        reset_n_in = 1'b0;
        {psel_in, penable_in, pwrite_in, phr_error_in} = 4'h0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        frame_in = '0;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        chk("irq", {31'h0, irq_out}, 32'h0);
        acc(0, A_CFG, 0);
        chk("cfg", r, rx_cfg_pkg::SYS_CFG_RESET);
        acc(0, A_MSK, 0);
        chk("mask", r, 32'h0);
        acc(0, 12'h080, 0);
        chk("slverr", {31'h0, e}, 32'h1);
        chk("unmapped", r, 32'h0);
        for (int c = 0; c < 5; c++) begin
            acc(1, A_CFG, CFGS[c]);
            for (int t = 4; t < 8; t++)
                frm(t[2:0], 10'h07F, 1'b1, EXPS[c][2*(t-4)+:2]);
        end
        acc(1, A_CFG, 32'h1241);
        frm(3'h6, 10'h004, 1'b1, 2'b01);
        acc(0, A_ST, 0);
        acc(1, A_MSK, 32'h1);
        hdr_err(1'b1);
        repeat (3) @(posedge clk_in);
        chk("irq_hi", {31'h0, irq_out}, 32'h1);
        spi_host_model_i.xfer(b);
        chk("link_rise", {24'h0, b}, 32'h1);
        acc(1, A_CFG, 32'h1440);
        spi_host_model_i.xfer(b);
        chk("link_fall", {24'h0, b}, 32'h1);
        chk("irq_lo", {31'h0, irq_out}, 32'h0);
        acc(0, A_ST, 0);
        chk("hdr_flag", {31'h0, r[0]}, 32'h1);
        acc(0, A_ST, 0);
        chk("irq_idle", {31'h0, irq_out}, 32'h1);
        chk("cleared", {31'h0, r[0]}, 32'h0);
        acc(1, A_CFG, 32'h3641);
        hdr_err(1'b0);
        acc(0, A_ST, 0);
        chk("hdr_kept", {31'h0, r[0]}, 32'h1);
        acc(1, A_CFG, 32'h0241);
        acc(1, A_BUF, 32'h3);
        acc(0, A_BUF, 0);
        w = r[2];
        m = w ? 2'b10 : 2'b01;
        acc(0, A_ST, 0);
        frm(3'h4, 10'h07F, 1'b1, 2'b10);
        chk("buf_idx", {31'h0, verdict_out.buf_index}, {31'h0, w});
        acc(0, A_BUF, 0);
        chk("buf_one", {29'h0, r[2:0]}, {29'h0, ~w, m});
        frm(3'h4, 10'h07F, 1'b0, 2'b01);
        acc(0, A_BUF, 0);
        chk("buf_drop", {29'h0, r[2:0]}, {29'h0, ~w, m});
        acc(1, A_CFG, 32'h0A41);
        frm(3'h4, 10'h07F, 1'b0, 2'b10);
        acc(0, A_BUF, 0);
        chk("buf_keep", {29'h0, r[2:0]}, {29'h0, w, 2'b11});
        frm(3'h4, 10'h07F, 1'b1, 2'b10);
        acc(0, A_ST, 0);
        chk("crc_ovr", r & 32'h18, 32'h18);
        acc(1, A_BUF, {30'h0, m});
        acc(0, A_BUF, 0);
        chk("buf_free", {29'h0, r[2:0]}, {29'h0, w, ~m});
        test_done();
    end
endmodule
`default_nettype wire
